// [hw/tlf_pkg.sv]
// Constants shared by the top-of-form line-feed inserter
package tlf_pkg;
  localparam int CHAR_W = 7;
  localparam int CNT_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [6:0] CODE_LF = 7'h0A;
  localparam logic [6:0] CODE_FF = 7'h0C;
  localparam logic [7:0] CNT_FULL = 8'h80;
  localparam logic [7:0] CNT_RESET = 8'h7F;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PHASE_TIME_NS = 1200;
  localparam int PHASE_CYC = PHASE_TIME_NS / CLK_PERIOD_NS;
  localparam int PHASE_CNT_W = 5;
  localparam logic [4:0] PHASE_LAST = 5'(PHASE_CYC - 1);
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_SINGLE = 4'h0;
  localparam logic [3:0] SEL_3_0 = 4'h1;
  localparam logic [3:0] SEL_3_5 = 4'h2;
  localparam logic [3:0] SEL_4_0 = 4'h3;
  localparam logic [3:0] SEL_5_5 = 4'h4;
  localparam logic [3:0] SEL_6_0 = 4'h5;
  localparam logic [3:0] SEL_7_0 = 4'h6;
  localparam logic [3:0] SEL_8_0 = 4'h7;
  localparam logic [3:0] SEL_8_5 = 4'h8;
  localparam logic [3:0] SEL_11_0 = 4'h9;
  localparam logic [3:0] SEL_12_0 = 4'hA;
  localparam logic [3:0] SEL_14_0 = 4'hB;
  localparam logic [7:0] PRE_SINGLE = 8'h7F;
  localparam logic [7:0] PRE_3_0 = 8'h6E;
  localparam logic [7:0] PRE_3_5 = 8'h6B;
  localparam logic [7:0] PRE_4_0 = 8'h68;
  localparam logic [7:0] PRE_5_5 = 8'h5F;
  localparam logic [7:0] PRE_6_0 = 8'h5C;
  localparam logic [7:0] PRE_7_0 = 8'h56;
  localparam logic [7:0] PRE_8_0 = 8'h50;
  localparam logic [7:0] PRE_8_5 = 8'h4D;
  localparam logic [7:0] PRE_11_0 = 8'h3E;
  localparam logic [7:0] PRE_12_0 = 8'h38;
  localparam logic [7:0] PRE_14_0 = 8'h2C;
  typedef enum logic [2:0] {
    TLF_IDLE = 3'b000,
    TLF_STAB = 3'b001,
    TLF_DECODE = 3'b011,
    TLF_RELOAD = 3'b010,
    TLF_STROBE = 3'b110
  } tlf_state_t;
endpackage

// [hw/tlf_top.sv]
// Top-of-form line-feed inserter and its output FIFO
// Operation
// - Line-feed with receiver strobe in decode phase increments line counter.
// - Increment reaching full count raises the top-of-form indication.
// - Reload phase with top-of-form loads the selected preset.
// - Line-feed without overflow: nothing until strobe phase forwards the character.
// - Form-feed with receiver strobe in decode phase sets form-feed pending.
// - Pending form-feed disables receiver, enables generator, increments in decode phase.
// - Receiver disabled: receiver data blocked, generated line-feeds sent instead.
// - Strobe phase of each form-feed cycle issues strobe with generated line-feed.
// - Overflow in a form-feed run sets top latch; acknowledge clears latch, which clears pending flag.
// - No overflow during form-feed run keeps pending flag set.
// - Acknowledge resets sequencer; still pending restarts it at once.
// - Each restarted sequence increments and emits one more line-feed.
// - After final acknowledge: counter reloaded, receiver on, generator off, waiting.
// - Selector gives fixed 8-bit preset for twelve settings.
// - Sequencer steps four phases, about 1.2 us each.
// - Sequencer starts on receiver strobe or pending form-feed.
// - Preset is 128 minus form line count; overflow when the count reaches 128.
// - Page-align button loads the currently selected preset, only while the sequencer is idle.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module tlf_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] fill_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (fill_q != (AW+1)'(DEPTH));
  assign out_valid = (fill_q != '0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      fill_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module tlf_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [6:0] rx_data,
  input wire logic char_valid_strobe,
  output logic rx_taken,
  output logic rx_enable,
  input wire logic [3:0] form_length_sel,
  input wire logic page_align_button,
  output logic [6:0] buf_data,
  output logic buf_valid,
  input wire logic buf_ready,
  output logic form_feed_pending,
  output logic form_top_reached,
  output logic [7:0] line_count,
  output logic phase_stabilise,
  output logic phase_decode_count,
  output logic phase_reload,
  output logic phase_strobe_out
);
  tlf_pkg::tlf_state_t state_q;
  tlf_pkg::tlf_state_t state_d;
  logic [4:0] tick_q;
  logic [7:0] count_q;
  logic [6:0] char_q;
  logic ff_pend_q;
  logic top_q;
  logic top_latch_q;
  logic from_rx_q;
  logic push_ready;

  // Preset table, selector value to starting count
  function automatic logic [7:0] preset_of(input logic [3:0] sel);
    case (sel)
      tlf_pkg::SEL_SINGLE: preset_of = tlf_pkg::PRE_SINGLE;
      tlf_pkg::SEL_3_0: preset_of = tlf_pkg::PRE_3_0;
      tlf_pkg::SEL_3_5: preset_of = tlf_pkg::PRE_3_5;
      tlf_pkg::SEL_4_0: preset_of = tlf_pkg::PRE_4_0;
      tlf_pkg::SEL_5_5: preset_of = tlf_pkg::PRE_5_5;
      tlf_pkg::SEL_6_0: preset_of = tlf_pkg::PRE_6_0;
      tlf_pkg::SEL_7_0: preset_of = tlf_pkg::PRE_7_0;
      tlf_pkg::SEL_8_0: preset_of = tlf_pkg::PRE_8_0;
      tlf_pkg::SEL_8_5: preset_of = tlf_pkg::PRE_8_5;
      tlf_pkg::SEL_11_0: preset_of = tlf_pkg::PRE_11_0;
      tlf_pkg::SEL_12_0: preset_of = tlf_pkg::PRE_12_0;
      tlf_pkg::SEL_14_0: preset_of = tlf_pkg::PRE_14_0;
      // Unused switch codes fall back to single line
      default: preset_of = tlf_pkg::PRE_SINGLE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Decode and selection
  wire phase_done = (tick_q == tlf_pkg::PHASE_LAST);
  wire rx_live = char_valid_strobe && !ff_pend_q;
  wire in_decode = (state_q == tlf_pkg::TLF_DECODE);
  wire is_lf = rx_live && (rx_data == tlf_pkg::CODE_LF);
  wire is_ff = rx_live && (rx_data == tlf_pkg::CODE_FF);
  wire do_inc = in_decode && phase_done && (is_lf || is_ff || ff_pend_q);
  wire [7:0] count_inc = count_q + 8'h01;
  wire hits_top = (count_inc == tlf_pkg::CNT_FULL);
  wire do_reload = (state_q == tlf_pkg::TLF_RELOAD) && phase_done && top_q;
  wire strobe_phase = (state_q == tlf_pkg::TLF_STROBE);
  wire push = strobe_phase && phase_done && push_ready;
  wire form_top_latch_clear = push && top_latch_q;
  wire restart = ff_pend_q && !form_top_latch_clear;
  wire start = rx_live || ff_pend_q;
  wire load_button = page_align_button && (state_q == tlf_pkg::TLF_IDLE);

  // Generator replaces the receiver while a form-feed run is active
  wire [6:0] decoded_char = (ff_pend_q || is_ff) ? tlf_pkg::CODE_LF : rx_data;

  assign rx_enable = !ff_pend_q;
  assign rx_taken = push && from_rx_q;
  assign form_feed_pending = ff_pend_q;
  assign form_top_reached = top_q;
  assign line_count = count_q;
  assign phase_stabilise = (state_q == tlf_pkg::TLF_STAB);
  assign phase_decode_count = in_decode;
  assign phase_reload = (state_q == tlf_pkg::TLF_RELOAD);
  assign phase_strobe_out = strobe_phase;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      tlf_pkg::TLF_IDLE: begin
        if (start) begin
          state_d = tlf_pkg::TLF_STAB;
        end
      end
      tlf_pkg::TLF_STAB: begin
        if (phase_done) begin
          state_d = tlf_pkg::TLF_DECODE;
        end
      end
      tlf_pkg::TLF_DECODE: begin
        if (phase_done) begin
          state_d = tlf_pkg::TLF_RELOAD;
        end
      end
      tlf_pkg::TLF_RELOAD: begin
        if (phase_done) begin
          state_d = tlf_pkg::TLF_STROBE;
        end
      end
      tlf_pkg::TLF_STROBE: begin
        // Full FIFO stalls here, holding the receiver off
        if (push) begin
          state_d = restart ? tlf_pkg::TLF_STAB : tlf_pkg::TLF_IDLE;
        end
      end
      default: state_d = tlf_pkg::TLF_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= tlf_pkg::TLF_IDLE;
      tick_q <= '0;
    end else begin
      state_q <= state_d;
      tick_q <= (state_d != state_q || phase_done) ? 5'h00 : tick_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= tlf_pkg::CNT_RESET;
    end else if (do_reload || load_button) begin
      count_q <= preset_of(form_length_sel);
    end else if (do_inc) begin
      count_q <= count_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      top_q <= 1'b0;
      top_latch_q <= 1'b0;
      ff_pend_q <= 1'b0;
      from_rx_q <= 1'b0;
      char_q <= '0;
    end else begin
      if (do_inc) begin
        top_q <= hits_top;
      end else if (state_q == tlf_pkg::TLF_IDLE) begin
        top_q <= 1'b0;
      end
      // Set wins over clear on both flags
      if (do_inc && hits_top && (ff_pend_q || is_ff)) begin
        top_latch_q <= 1'b1;
      end else if (form_top_latch_clear) begin
        top_latch_q <= 1'b0;
      end
      if (in_decode && phase_done && is_ff) begin
        ff_pend_q <= 1'b1;
      end else if (form_top_latch_clear) begin
        ff_pend_q <= 1'b0;
      end
      if (in_decode && phase_done) begin
        char_q <= decoded_char;
        from_rx_q <= rx_live;
      end else if (push) begin
        from_rx_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output buffer toward the character buffer
  tlf_fifo #(
    .WIDTH(tlf_pkg::CHAR_W),
    .DEPTH(tlf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(char_q),
    .in_valid(strobe_phase && phase_done),
    .in_ready(push_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready)
  );
endmodule

// [verification/tlf_checker.sv]
// Assertion checker for the top-of-form line-feed inserter
`timescale 1ns/1ns
module tlf_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic char_valid_strobe,
  input wire logic rx_taken,
  input wire logic rx_enable,
  input wire logic page_align_button,
  input wire logic form_feed_pending,
  input wire logic form_top_reached,
  input wire logic [7:0] line_count,
  input wire logic phase_stabilise,
  input wire logic phase_decode_count,
  input wire logic phase_reload,
  input wire logic phase_strobe_out
);
  logic busy;
  assign busy = phase_stabilise | phase_decode_count | phase_reload | phase_strobe_out;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_onehot; $onehot0({phase_stabilise, phase_decode_count, phase_reload, phase_strobe_out}); endproperty
  property p_start; !busy && char_valid_strobe && !form_feed_pending |=> phase_stabilise; endproperty
  property p_decode_len; $rose(phase_decode_count) |-> ##24 phase_reload; endproperty
  property p_order; $fell(phase_stabilise) |-> phase_decode_count; endproperty
  property p_strobe; $rose(phase_strobe_out) |-> $past(phase_reload); endproperty
  property p_take; rx_taken |-> phase_strobe_out && char_valid_strobe; endproperty
  // Counter may move only at decode end, reload end or an idle button press
  property p_cnt_src; $changed(line_count) |-> $past(phase_decode_count) || $past(phase_reload)
    || $past(page_align_button && !busy); endproperty
  property p_run_inc; $rose(phase_reload) && form_feed_pending |-> line_count == 8'($past(line_count) + 8'h01); endproperty
  property p_top; $rose(phase_reload) && line_count == tlf_pkg::CNT_FULL |-> form_top_reached; endproperty
  property p_reload; $fell(phase_reload) && form_top_reached |-> line_count < tlf_pkg::CNT_FULL; endproperty
  property p_hold; form_feed_pending && !form_top_reached |=> form_feed_pending; endproperty
  property p_clear; $fell(form_feed_pending) |-> $past(form_top_reached) && $past(phase_strobe_out); endproperty
  property p_restart; $fell(phase_strobe_out) && form_feed_pending |-> phase_stabilise; endproperty
  // Pending may only rise at the end of a decode phase
  property p_rx_off; $rose(form_feed_pending) |-> !rx_enable && phase_reload && $past(phase_decode_count); endproperty
  a_onehot: assert property (p_onehot) else $error("phases overlap");
  a_start: assert property (p_start) else $error("sequencer did not start");
  a_decode_len: assert property (p_decode_len) else $error("decode phase length wrong");
  a_order: assert property (p_order) else $error("stabilise not followed by decode");
  a_strobe: assert property (p_strobe) else $error("strobe phase not after reload");
  a_take: assert property (p_take) else $error("character taken outside strobe phase");
  a_cnt_src: assert property (p_cnt_src) else $error("counter moved at wrong time");
  a_run_inc: assert property (p_run_inc) else $error("run did not count by one");
  a_top: assert property (p_top) else $error("full count without top flag");
  a_reload: assert property (p_reload) else $error("no reload at top of form");
  a_hold: assert property (p_hold) else $error("pending dropped early");
  a_clear: assert property (p_clear) else $error("pending cleared without top");
  a_restart: assert property (p_restart) else $error("run sequence not restarted");
  a_rx_off: assert property (p_rx_off) else $error("receiver left enabled in run");
  c_run_end: cover property ($fell(form_feed_pending));
  c_top: cover property ($rose(form_top_reached));
  c_take: cover property (rx_taken);
endmodule

bind tlf_top tlf_checker tlf_checker_i (.clock(clock), .rst_n(rst_n), .char_valid_strobe(char_valid_strobe),
  .rx_taken(rx_taken), .rx_enable(rx_enable), .page_align_button(page_align_button),
  .form_feed_pending(form_feed_pending), .form_top_reached(form_top_reached), .line_count(line_count),
  .phase_stabilise(phase_stabilise), .phase_decode_count(phase_decode_count), .phase_reload(phase_reload),
  .phase_strobe_out(phase_strobe_out));

// [verification/tlf_partner.sv]
// Receiver and character-buffer model facing the inserter
`timescale 1ns/1ns
module tlf_partner (
  input wire logic clock,
  input wire logic rst_n,
  output logic [6:0] rx_data,
  output logic char_valid_strobe,
  input wire logic rx_taken,
  input wire logic [6:0] buf_data,
  input wire logic buf_valid,
  output logic buf_ready
);
  logic [6:0] send_q [$];
  logic [6:0] got_q [$];
  logic stall;
  initial begin
    rx_data = 7'h00;
    char_valid_strobe = 1'b0;
    buf_ready = 1'b0;
    stall = 1'b0;
  end
  always @(posedge clock) begin
    if (rst_n && buf_valid && buf_ready) got_q.push_back(buf_data);
    if (rst_n && char_valid_strobe && rx_taken) void'(send_q.pop_front());
    #1;
    buf_ready = rst_n && !stall;
    // Idle data toggles so a stale character can never look valid
    rx_data = (rst_n && send_q.size() != 0) ? send_q[0] : ~rx_data;
    char_valid_strobe = rst_n && send_q.size() != 0;
  end
endmodule

// [verification/tlf_top_tb.sv]
// Self-checking testbench for the top-of-form line-feed inserter
`timescale 1ns/1ns
module tlf_top_tb;
  logic clock, rst_n, char_valid_strobe, rx_taken, rx_enable, page_align_button, buf_valid, buf_ready;
  logic form_feed_pending, form_top_reached, phase_stabilise, phase_decode_count, phase_reload, phase_strobe_out;
  logic [6:0] rx_data;
  logic [6:0] buf_data;
  logic [3:0] form_length_sel;
  logic [7:0] line_count;
  int bad_count = 0;
  int checked = 0;
  tlf_top tlf_top_i (.clock(clock), .rst_n(rst_n), .rx_data(rx_data), .char_valid_strobe(char_valid_strobe),
    .rx_taken(rx_taken), .rx_enable(rx_enable), .form_length_sel(form_length_sel),
    .page_align_button(page_align_button), .buf_data(buf_data), .buf_valid(buf_valid), .buf_ready(buf_ready),
    .form_feed_pending(form_feed_pending), .form_top_reached(form_top_reached), .line_count(line_count),
    .phase_stabilise(phase_stabilise), .phase_decode_count(phase_decode_count), .phase_reload(phase_reload),
    .phase_strobe_out(phase_strobe_out));
  tlf_partner tlf_partner_i (.clock(clock), .rst_n(rst_n), .rx_data(rx_data), .char_valid_strobe(char_valid_strobe),
    .rx_taken(rx_taken), .buf_data(buf_data), .buf_valid(buf_valid), .buf_ready(buf_ready));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Bounded wait for queue, sequencer, run and FIFO all empty
  task automatic drain();
    int n;
    n = 0;
    while ((tlf_partner_i.send_q.size() != 0 || buf_valid !== 1'b0 || form_feed_pending !== 1'b0
      || {phase_stabilise, phase_decode_count, phase_reload, phase_strobe_out} !== 4'h0) && n < 6000) begin
      cyc(1);
      n++;
    end
    check("drain bound", 8'(n == 6000), 8'h00);
  endtask
  task automatic load(input logic [3:0] sel);
    form_length_sel = sel;
    page_align_button = 1'b1;
    cyc(1);
    page_align_button = 1'b0;
    cyc(1);
  endtask
  task automatic send(input logic [6:0] c);
    tlf_partner_i.send_q.push_back(c);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("reset count", line_count, 8'h7F);
    check("reset rx enable", 8'(rx_enable), 8'h01);
    check("reset pending", 8'(form_feed_pending), 8'h00);
    $display("done reset");
  endtask
  task automatic t_presets();
    logic [7:0] pre [0:12];
    pre = '{8'h7F, 8'h6E, 8'h6B, 8'h68, 8'h5F, 8'h5C, 8'h56, 8'h50, 8'h4D, 8'h3E, 8'h38, 8'h2C, 8'h7F};
    for (int i = 0; i < 13; i++) begin
      load(4'(i));
      check("preset", line_count, pre[i]);
    end
    $display("done presets");
  endtask
  task automatic t_plain();
    load(4'h1);
    send(7'h41);
    drain();
    check("plain char", 8'(tlf_partner_i.got_q[0]), 8'h41);
    check("plain count", line_count, 8'h6E);
    $display("done plain");
  endtask
  task automatic t_lf();
    load(4'h0);
    send(7'h0A);
    drain();
    check("wrap count", line_count, 8'h7F);
    load(4'h1);
    send(7'h0A);
    drain();
    check("lf count", line_count, 8'h6F);
    check("forwarded", 8'(tlf_partner_i.got_q.size()), 8'h03);
    check("lf char", 8'(tlf_partner_i.got_q[2]), 8'h0A);
    tlf_partner_i.got_q.delete();
    $display("done line feed");
  endtask
  // Buffer stalls so the FIFO fills; a character waits behind the run
  task automatic t_ff();
    tlf_partner_i.stall = 1'b1;
    send(7'h0C);
    send(7'h41);
    cyc(1500);
    check("run pending", 8'(form_feed_pending), 8'h01);
    check("run rx off", 8'(rx_enable), 8'h00);
    tlf_partner_i.stall = 1'b0;
    drain();
    check("run length", 8'(tlf_partner_i.got_q.size()), 8'h12);
    for (int i = 0; i < 17; i++) check("run char", 8'(tlf_partner_i.got_q[i]), 8'h0A);
    check("after run char", 8'(tlf_partner_i.got_q[17]), 8'h41);
    check("after run count", line_count, 8'h6E);
    check("after run rx on", 8'(rx_enable), 8'h01);
    $display("done form feed");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 50);
    bad_count++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    page_align_button = 1'b0;
    form_length_sel = 4'h0;
    cyc(8);
    rst_n = 1'b1;
    t_reset();
    t_presets();
    t_plain();
    t_lf();
    t_ff();
    summarize();
  end
endmodule
